// [dv/adc_source.sv]
// Behavioural far-side sample source: link clock and pixel samples
`timescale 1ns/1ps
`default_nettype none
module adc_source (
   // Frame qualifier from the block
   input wire logic frame,
   // Link clock and sample
   output logic adc_clk,
   output logic [9:0] adc_sample
);
   // Clock stands still outside frames; sample changes every half period
   initial begin
      adc_clk = 1'b0;
      adc_sample = 10'h2aa;
      #7;
      forever begin
         #160;
         adc_clk = frame & ~adc_clk;
         adc_sample = ~adc_sample + 10'h001; // Ten-bit sample
      end
   end
endmodule : adc_source
`default_nettype wire

// [dv/readout_sva.sv]
// Concurrent checks on the readout sequencer ports
`timescale 1ns/1ps
`default_nettype none
module readout_sva (
   // Clock, reset, enable
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // Bus answers
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Pixel port and array side
   input wire logic [9:0] PIX_DATA,
   input wire logic LINE_VALID,
   input wire logic FRAME_VALID,
   input wire logic pixel_rate_clock_out,
   input wire logic ROW_RESET_STB,
   input wire logic [10:0] ARRAY_COL,
   input wire logic [10:0] ARRAY_ROW
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   a_line_in_frame: assert property (LINE_VALID |-> FRAME_VALID)
      else $error("line valid outside frame");
   a_pclk_toggles: assert property (CLK_EN && !SYS_RST |=>
      pixel_rate_clock_out != $past(pixel_rate_clock_out))
      else $error("pixel clock did not toggle");
   a_blank_zero: assert property (!LINE_VALID |-> PIX_DATA == 10'h000)
      else $error("data not zero in blanking");
   a_freeze_hold: assert property (!CLK_EN |=> $stable(pixel_rate_clock_out) && $stable(LINE_VALID))
      else $error("state moved while clock enable low");
   a_addr_range: assert property (ARRAY_COL <= 11'h697 && ARRAY_ROW <= 11'h4e7)
      else $error("array address out of range");
   a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write answer dropped");
   a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
      else $error("read answer dropped");
   a_frame_end_quiet: assert property ($fell(FRAME_VALID) |-> !LINE_VALID)
      else $error("line valid at frame end");
   a_reset_strobe: assert property (ROW_RESET_STB |=> !ROW_RESET_STB)
      else $error("row reset strobe too long");
   // Main scenarios
   c_line: cover property ($rose(LINE_VALID));
   c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
   c_row_reset: cover property (ROW_RESET_STB);
   c_freeze: cover property (!CLK_EN);
endmodule : readout_sva
bind sensor_readout readout_sva u_readout_sva (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
   .CLK_EN(CLK_EN), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PIX_DATA(PIX_DATA),
   .LINE_VALID(LINE_VALID), .FRAME_VALID(FRAME_VALID),
   .pixel_rate_clock_out(pixel_rate_clock_out), .ROW_RESET_STB(ROW_RESET_STB),
   .ARRAY_COL(ARRAY_COL), .ARRAY_ROW(ARRAY_ROW));
`default_nettype wire

// [dv/sensor_readout_bench.sv]
// Self-checking bench for the readout sequencer
`timescale 1ns/1ps
`default_nettype none
module sensor_readout_bench;
   logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic ce = 1'b1, aedge; // Clock enable and link edge seen
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat;
   logic [1:0] bres, rres;
   logic awr, wr, bv, arr, rv, lv, fv, grn, redr, adc_c;
   logic [9:0] pix, adc_s;
   logic [10:0] arow;
   int mismatches = 0, n_tests = 0;
   // Master clock
   always #20 clk = ~clk;
   // Far-side sample source
   adc_source u_adc_source (.frame(fv), .adc_clk(adc_c), .adc_sample(adc_s));
   sensor_readout u_sensor_readout (.REF_CLK(clk), .SYS_RST(rst), .CLK_EN(ce),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bres),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rres), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rrdy), .ADC_SAMPLE(adc_s), .ADC_CLK(adc_c), .PIX_DATA(pix),
      .LINE_VALID(lv), .FRAME_VALID(fv), .PIX_GREEN(grn), .PIX_RED_ROW(redr),
      .pixel_rate_clock_out(), .ROW_RESET_ADDR(), .ROW_RESET_STB(), .ARRAY_COL(),
      .ARRAY_ROW(arow), .ADC_EDGE(aedge));
   // Counts and verdict
   task automatic conclude;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   // One comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Wait ran out
   task automatic hang;
      mismatches++;
      conclude();
   endtask : hang
   // Bus write: address and data offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      for (n = 0; n < 50 && !bv; n++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
      end
      if (!bv) hang();
      r = bres;
      brdy <= 1'b0;
   endtask : axw
   // Bus read
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      for (n = 0; n < 50 && !rv; n++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end
      if (!rv) hang();
      d = rdat;
      r = rres;
      rrdy <= 1'b0;
   endtask : axr
   // First line of the default frame: width, row, colour, blanking
   task automatic t_stream;
      int n, hi, lo, ne;
      for (n = 0; n < 90000 && !lv; n++) @(posedge clk);
      if (!lv) hang();
      chk(fv, 1'b1);
      chk({grn, redr}, 2'b11);
      ne = 0;
      for (hi = 0; hi < 5000 && lv; hi++) begin
         if (hi == 1) chk({grn, redr}, 2'b01);
         if (hi == 100) chk(arow, 11'h01c);
         if (hi == 100) chk(pix == 10'h2aa || pix == 10'h156, 1'b1);
         if (aedge) ne++;
         @(posedge clk);
      end
      chk(hi, 1600);
      chk(ne, 200);
      // Eight frozen edges inside the blanking stretch lengthen it by eight
      for (lo = 0; lo < 5000 && !lv; lo++) begin
         if (pix !== 10'h000) chk(pix, 10'h000);
         if (lo == 10) ce <= 1'b0;
         if (lo == 18) ce <= 1'b1;
         @(posedge clk);
      end
      chk(lo, 357);
   endtask : t_stream
   // Register reset values
   task automatic t_defaults;
      logic [7:0] a[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
      logic [31:0] e[8] = '{32'h1, 32'h1c, 32'h3c, 32'h4b0, 32'h640, 32'h15c, 32'h20, 32'h10};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 8; i++) begin
         axr(a[i], d, r);
         chk(d, e[i]);
      end
   endtask : t_defaults
   // Unmapped and read-only places refused
   task automatic t_refuse;
      logic [31:0] d;
      logic [1:0] r;
      axw(8'h24, 32'h1234, r);
      chk(r, readout_pkg::RESP_SLVERR);
      axw(readout_pkg::REG_STATUS, 32'h1, r);
      chk(r, readout_pkg::RESP_SLVERR);
      axr(8'h24, d, r);
      chk({d, r}, {32'h0, readout_pkg::RESP_SLVERR});
   endtask : t_refuse
   // Host writes a setting directly
   task automatic t_direct;
      logic [31:0] d;
      logic [1:0] r;
      axw(readout_pkg::REG_HBLANK, 32'h5, r);
      chk(r, readout_pkg::RESP_OKAY);
      axr(readout_pkg::REG_HBLANK, d, r);
      chk(d, 32'h5);
   endtask : t_direct
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_stream();
      t_defaults();
      t_refuse();
      t_direct();
      conclude();
   end
endmodule : sensor_readout_bench
`default_nettype wire

// [rtl/readout_pkg.sv]
// Constants for the sensor-core readout sequencer
package readout_pkg;
   // Array geometry
   localparam int unsigned ARR_COLS = 1688;
   localparam int unsigned ARR_ROWS = 1256;
   localparam int unsigned CNT_W = 11;
   localparam logic [10:0] BLACK_LEFT_COLS = 11'h034;
   localparam logic [10:0] BLACK_RIGHT_COLS = 11'h004;
   localparam logic [10:0] BLACK_EDGE_ROWS = 11'h014;
   localparam logic [10:0] COL_LAST = 11'h697;
   localparam logic [10:0] ROW_LAST = 11'h4e7;
   // Default window
   localparam logic [10:0] WIN_ROW_START_RST = 11'h01c;
   localparam logic [10:0] WIN_COL_START_RST = 11'h03c;
   localparam logic [10:0] WIN_WIDTH_RST = 11'h640;
   localparam logic [10:0] WIN_HEIGHT_RST = 11'h4b0;
   localparam logic [10:0] BORDER_PIX = 11'h004;
   localparam logic [10:0] MIRROR_SHIFT = 11'h001;
   // Blanking defaults
   localparam logic [15:0] HBLANK_RST = 16'h015c;
   localparam logic [15:0] VBLANK_RST = 16'h0020;
   localparam logic [15:0] EXPOSURE_RST = 16'h0010;
   // Pixel width
   localparam int unsigned PIX_W = 10;
   // AXI4-Lite register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ROW_START = 8'h04;
   localparam logic [7:0] REG_COL_START = 8'h08;
   localparam logic [7:0] REG_HEIGHT = 8'h0c;
   localparam logic [7:0] REG_WIDTH = 8'h10;
   localparam logic [7:0] REG_HBLANK = 8'h14;
   localparam logic [7:0] REG_VBLANK = 8'h18;
   localparam logic [7:0] REG_EXPOSURE = 8'h1c;
   localparam logic [7:0] REG_STATUS = 8'h20;
   // Control fields
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_BORDER_BIT = 1;
   localparam int unsigned CTRL_MIRROR_COL_BIT = 2;
   localparam int unsigned CTRL_MIRROR_ROW_BIT = 3;
   localparam logic [15:0] CTRL_RST = 16'h0001;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_LINE, ST_HBLANK, ST_VBLANK} seq_state_t;
endpackage : readout_pkg

// [rtl/readout_regs.sv]
// AXI4-Lite register slave for the readout sequencer
`timescale 1ns/1ps
`default_nettype none
module readout_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // AXI4-Lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Pending settings
   output logic [15:0] ctrl,
   output logic [15:0] row_start,
   output logic [15:0] col_start,
   output logic [15:0] height,
   output logic [15:0] width,
   output logic [15:0] hblank,
   output logic [15:0] vblank,
   output logic [15:0] exposure,
   // Status from sequencer
   input wire logic [15:0] status
);
   // Address hit test
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= readout_pkg::REG_STATUS) && (a[1:0] == 2'b00);
   endfunction : mapped

   // Merge 16 bits of write data under byte strobes
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   logic [7:0] aw_r, aw_nxt; // Held write address
   logic aw_ok_r, aw_ok_nxt; // Write address held
   logic [31:0] wd_r, wd_nxt; // Held write data
   logic [3:0] ws_r, ws_nxt; // Held strobes
   logic w_ok_r, w_ok_nxt; // Write data held
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [15:0] regs_r [8], regs_nxt [8]; // Writable registers by index

   // Next-state for bus channels and registers
   always_comb begin
      aw_nxt = aw_r;
      aw_ok_nxt = aw_ok_r;
      wd_nxt = wd_r;
      ws_nxt = ws_r;
      w_ok_nxt = w_ok_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      regs_nxt = regs_r;
      // Capture address and data in either order
      if (awvalid && !aw_ok_r) begin
         aw_nxt = awaddr;
         aw_ok_nxt = 1'b1;
      end
      if (wvalid && !w_ok_r) begin
         wd_nxt = wdata;
         ws_nxt = wstrb;
         w_ok_nxt = 1'b1;
      end
      // Perform write once both halves are present
      if (aw_ok_r && w_ok_r && !bvalid_r) begin
         aw_ok_nxt = 1'b0;
         w_ok_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         if (mapped(aw_r) && aw_r != readout_pkg::REG_STATUS) begin
            bresp_nxt = readout_pkg::RESP_OKAY;
            regs_nxt[aw_r[4:2]] = merge(regs_r[aw_r[4:2]], wd_r, ws_r);
         end else begin
            bresp_nxt = readout_pkg::RESP_SLVERR;
         end
      end else if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
      end
      // Read channel
      if (arvalid && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = mapped(araddr) ? readout_pkg::RESP_OKAY : readout_pkg::RESP_SLVERR;
         if (araddr == readout_pkg::REG_STATUS)
            rdata_nxt = {16'h0000, status};
         else if (mapped(araddr))
            rdata_nxt = {16'h0000, regs_r[araddr[4:2]]};
         else
            rdata_nxt = 32'h0000_0000;
      end else if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // Register the bus state
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_r <= 8'h00;
         aw_ok_r <= 1'b0;
         wd_r <= 32'h0000_0000;
         ws_r <= 4'h0;
         w_ok_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'b00;
         rvalid_r <= 1'b0;
         rresp_r <= 2'b00;
         rdata_r <= 32'h0000_0000;
         regs_r[0] <= readout_pkg::CTRL_RST;
         regs_r[1] <= {5'h00, readout_pkg::WIN_ROW_START_RST};
         regs_r[2] <= {5'h00, readout_pkg::WIN_COL_START_RST};
         regs_r[3] <= {5'h00, readout_pkg::WIN_HEIGHT_RST};
         regs_r[4] <= {5'h00, readout_pkg::WIN_WIDTH_RST};
         regs_r[5] <= readout_pkg::HBLANK_RST;
         regs_r[6] <= readout_pkg::VBLANK_RST;
         regs_r[7] <= readout_pkg::EXPOSURE_RST;
      end else if (ce) begin
         aw_r <= aw_nxt;
         aw_ok_r <= aw_ok_nxt;
         wd_r <= wd_nxt;
         ws_r <= ws_nxt;
         w_ok_r <= w_ok_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         regs_r <= regs_nxt;
      end
   end

   // Ready while the holding slot is empty
   assign awready = !aw_ok_r;
   assign wready = !w_ok_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = !rvalid_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign ctrl = regs_r[0];
   assign row_start = regs_r[1];
   assign col_start = regs_r[2];
   assign height = regs_r[3];
   assign width = regs_r[4];
   assign hblank = regs_r[5];
   assign vblank = regs_r[6];
   assign exposure = regs_r[7];
endmodule : readout_regs
`default_nettype wire

// [rtl/sensor_readout.sv]
// Sensor-core readout sequencer: array scan, window, blanking and pixel port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Counters cover 1688 columns by 1256 rows
// - First 52 columns, edge 20 rows black
// - Last 4 columns also black
// - Default window 1600 by 1200
// - Default window starts row 28, column 60
// - Border option adds four pixels each side
// - Mirroring shifts window one pixel
// - Bayer colour by row and column parity
// - Each pixel is a 10-bit value
// - One pixel per master clock
// - Rows reset, integrate, then read
// - Progressive stream with line and frame valid
// - Line valid only on image pixels
// - Horizontal and vertical blanking programmable
// - Array scan starts at a window corner, clamped into the clear region
// - 16-bit registers reachable by host
// - Host writes settings directly
// - One pixel word per clock while valid
module sensor_readout (
   // Clock, reset, enable
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // AXI4-Lite slave
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Analog chain sample for the addressed pixel, from the link domain
   input wire logic [9:0] ADC_SAMPLE,
   input wire logic ADC_CLK,
   // Pixel port
   output logic [9:0] PIX_DATA,
   output logic LINE_VALID,
   output logic FRAME_VALID,
   output logic PIX_GREEN,
   output logic PIX_RED_ROW,
   output logic pixel_rate_clock_out,
   // Array addressing for row reset and row read
   output logic [10:0] ROW_RESET_ADDR,
   output logic ROW_RESET_STB,
   output logic [10:0] ARRAY_COL,
   output logic [10:0] ARRAY_ROW,
   output logic ADC_EDGE
);
   // Pending register values
   logic [15:0] ctrl, row_start, col_start, height, width, hblank, vblank, exposure;
   logic [15:0] status;
   // Live copies, loaded at frame start
   logic [15:0] live_ctrl_r, live_ctrl_nxt;
   logic [10:0] live_rs_r, live_rs_nxt, live_cs_r, live_cs_nxt;
   logic [10:0] live_h_r, live_h_nxt, live_w_r, live_w_nxt;
   logic [15:0] live_hb_r, live_hb_nxt, live_vb_r, live_vb_nxt, live_exp_r, live_exp_nxt;
   // Scan counters
   readout_pkg::seq_state_t st_r, st_nxt;
   logic [10:0] col_r, col_nxt; // Column within window
   logic [10:0] row_r, row_nxt; // Row within window
   logic [15:0] blank_r, blank_nxt; // Blanking counter
   logic [15:0] frames_r, frames_nxt; // Frame count for status
   // Outputs
   logic [9:0] pix_r, pix_nxt;
   logic lv_r, lv_nxt, fv_r, fv_nxt;
   logic grn_r, grn_nxt, redrow_r, redrow_nxt;
   logic pclk_r, pclk_nxt;
   logic [10:0] rst_addr_r, rst_addr_nxt;
   logic rst_stb_r, rst_stb_nxt;
   logic [10:0] acol_r, acol_nxt, arow_r, arow_nxt;
   // Link-clock synchroniser and edge detect
   logic [9:0] smp_s1_r, smp_s2_r;
   logic lck_s1_r, lck_s2_r, lck_d_r, edge_r;

   // Window edges including border and mirror shift
   function automatic logic [10:0] win_start(input logic [10:0] s, input logic bord,
                                             input logic mir);
      logic [10:0] v;
      v = s;
      if (bord) v = v - readout_pkg::BORDER_PIX;
      if (mir) v = v + readout_pkg::MIRROR_SHIFT;
      win_start = v;
   endfunction : win_start

   function automatic logic [10:0] win_len(input logic [10:0] n, input logic bord);
      win_len = bord ? n + (readout_pkg::BORDER_PIX << 1) : n;
   endfunction : win_len

   // Map a window offset to an array address, reversed when mirrored
   function automatic logic [10:0] arr_addr(input logic [10:0] base, input logic [10:0] len,
                                            input logic [10:0] off, input logic mir);
      arr_addr = mir ? base + len - 11'h001 - off : base + off;
   endfunction : arr_addr

   // Clamp an address into the clear region of the array
   function automatic logic [10:0] clamp(input logic [10:0] a, input logic [10:0] lo,
                                         input logic [10:0] hi);
      clamp = (a < lo) ? lo : (a > hi) ? hi : a;
   endfunction : clamp

   // Register slave
   readout_regs u_regs (
      .clk(REF_CLK), .rst(SYS_RST), .ce(CLK_EN),
      .awaddr(S_AXI_AWADDR), .awvalid(S_AXI_AWVALID), .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA), .wstrb(S_AXI_WSTRB), .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY), .bresp(S_AXI_BRESP), .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY), .araddr(S_AXI_ARADDR), .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY), .rdata(S_AXI_RDATA), .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID), .rready(S_AXI_RREADY),
      .ctrl(ctrl), .row_start(row_start), .col_start(col_start), .height(height),
      .width(width), .hblank(hblank), .vblank(vblank), .exposure(exposure),
      .status(status)
   );

   // Status: state, line valid, frame valid, frame count low bits
   assign status = {frames_r[11:0], fv_r, lv_r, st_r};

   // Two-flop synchronisers for the link clock and sample bus
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         smp_s1_r <= 10'h000;
         smp_s2_r <= 10'h000;
         lck_s1_r <= 1'b0;
         lck_s2_r <= 1'b0;
         lck_d_r <= 1'b0;
         edge_r <= 1'b0;
      end else if (CLK_EN) begin
         smp_s1_r <= ADC_SAMPLE;
         smp_s2_r <= smp_s1_r;
         lck_s1_r <= ADC_CLK;
         lck_s2_r <= lck_s1_r;
         lck_d_r <= lck_s2_r;
         edge_r <= lck_s2_r && !lck_d_r;
      end
   end

   // Sequencer next state
   always_comb begin
      logic [10:0] r0, c0, wl, hl, ar, ac;
      logic bord, mc, mr;
      r0 = 11'h000;
      c0 = 11'h000;
      wl = 11'h000;
      hl = 11'h000;
      ar = 11'h000;
      ac = 11'h000;
      bord = live_ctrl_r[readout_pkg::CTRL_BORDER_BIT];
      mc = live_ctrl_r[readout_pkg::CTRL_MIRROR_COL_BIT];
      mr = live_ctrl_r[readout_pkg::CTRL_MIRROR_ROW_BIT];
      st_nxt = st_r;
      col_nxt = col_r;
      row_nxt = row_r;
      blank_nxt = blank_r;
      frames_nxt = frames_r;
      live_ctrl_nxt = live_ctrl_r;
      live_rs_nxt = live_rs_r;
      live_cs_nxt = live_cs_r;
      live_h_nxt = live_h_r;
      live_w_nxt = live_w_r;
      live_hb_nxt = live_hb_r;
      live_vb_nxt = live_vb_r;
      live_exp_nxt = live_exp_r;
      rst_stb_nxt = 1'b0;
      rst_addr_nxt = rst_addr_r;
      pclk_nxt = !pclk_r;
      wl = win_len(live_w_r, bord);
      hl = win_len(live_h_r, bord);
      r0 = win_start(live_rs_r, bord, mr);
      c0 = win_start(live_cs_r, bord, mc);
      case (st_r)
         // Wait for run enable; load live settings at frame start
         readout_pkg::ST_IDLE: begin
            if (ctrl[readout_pkg::CTRL_RUN_BIT]) begin
               live_ctrl_nxt = ctrl;
               live_rs_nxt = row_start[10:0];
               live_cs_nxt = col_start[10:0];
               live_h_nxt = height[10:0];
               live_w_nxt = width[10:0];
               live_hb_nxt = hblank;
               live_vb_nxt = vblank;
               live_exp_nxt = exposure;
               col_nxt = 11'h000;
               row_nxt = 11'h000;
               st_nxt = readout_pkg::ST_LINE;
            end
         end
         // Emit one pixel per clock across the window width
         readout_pkg::ST_LINE: begin
            if (col_r == wl - 11'h001) begin
               col_nxt = 11'h000;
               blank_nxt = live_hb_r;
               st_nxt = readout_pkg::ST_HBLANK;
            end else begin
               col_nxt = col_r + 11'h001;
            end
         end
         // Horizontal blanking; rows reset ahead of their read
         readout_pkg::ST_HBLANK: begin
            if (blank_r == 16'h0000) begin
               // Reset the row that will be read exposure rows later
               rst_stb_nxt = 1'b1;
               if (row_r == hl - 11'h001) begin
                  row_nxt = 11'h000;
                  blank_nxt = live_vb_r;
                  st_nxt = readout_pkg::ST_VBLANK;
               end else begin
                  row_nxt = row_r + 11'h001;
                  st_nxt = readout_pkg::ST_LINE;
               end
            end else begin
               blank_nxt = blank_r - 16'h0001;
            end
         end
         // Vertical blanking, counted in row times of hblank plus width
         readout_pkg::ST_VBLANK: begin
            if (col_r == wl + live_hb_r[10:0]) begin
               col_nxt = 11'h000;
               if (blank_r == 16'h0000) begin
                  frames_nxt = frames_r + 16'h0001;
                  st_nxt = readout_pkg::ST_IDLE;
               end else begin
                  blank_nxt = blank_r - 16'h0001;
               end
            end else begin
               col_nxt = col_r + 11'h001;
            end
         end
         default: st_nxt = readout_pkg::ST_IDLE;
      endcase
      // Address, colour and data all follow the state being entered, so they line up
      ar = clamp(arr_addr(r0, hl, row_nxt, mr), readout_pkg::BLACK_EDGE_ROWS,
                 readout_pkg::ROW_LAST - readout_pkg::BLACK_EDGE_ROWS);
      ac = clamp(arr_addr(c0, wl, col_nxt, mc), readout_pkg::BLACK_LEFT_COLS,
                 readout_pkg::COL_LAST - readout_pkg::BLACK_RIGHT_COLS);
      if (rst_stb_nxt) rst_addr_nxt = ar + live_exp_r[10:0];
      lv_nxt = (st_nxt == readout_pkg::ST_LINE);
      fv_nxt = (st_nxt == readout_pkg::ST_LINE) || (st_nxt == readout_pkg::ST_HBLANK);
      arow_nxt = ar;
      acol_nxt = ac;
      pix_nxt = lv_nxt ? smp_s2_r : 10'h000;
      // Colour from array parity, unchanged by mirroring
      grn_nxt = ~(ac[0] ^ ar[0]);
      redrow_nxt = ~ar[0];
   end

   // Register the sequencer
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         st_r <= readout_pkg::ST_IDLE;
         col_r <= 11'h000;
         row_r <= 11'h000;
         blank_r <= 16'h0000;
         frames_r <= 16'h0000;
         live_ctrl_r <= readout_pkg::CTRL_RST;
         live_rs_r <= readout_pkg::WIN_ROW_START_RST;
         live_cs_r <= readout_pkg::WIN_COL_START_RST;
         live_h_r <= readout_pkg::WIN_HEIGHT_RST;
         live_w_r <= readout_pkg::WIN_WIDTH_RST;
         live_hb_r <= readout_pkg::HBLANK_RST;
         live_vb_r <= readout_pkg::VBLANK_RST;
         live_exp_r <= readout_pkg::EXPOSURE_RST;
         pix_r <= 10'h000;
         lv_r <= 1'b0;
         fv_r <= 1'b0;
         grn_r <= 1'b0;
         redrow_r <= 1'b0;
         pclk_r <= 1'b0;
         rst_addr_r <= 11'h000;
         rst_stb_r <= 1'b0;
         acol_r <= readout_pkg::BLACK_LEFT_COLS;
         arow_r <= readout_pkg::BLACK_EDGE_ROWS;
      end else if (CLK_EN) begin
         st_r <= st_nxt;
         col_r <= col_nxt;
         row_r <= row_nxt;
         blank_r <= blank_nxt;
         frames_r <= frames_nxt;
         live_ctrl_r <= live_ctrl_nxt;
         live_rs_r <= live_rs_nxt;
         live_cs_r <= live_cs_nxt;
         live_h_r <= live_h_nxt;
         live_w_r <= live_w_nxt;
         live_hb_r <= live_hb_nxt;
         live_vb_r <= live_vb_nxt;
         live_exp_r <= live_exp_nxt;
         pix_r <= pix_nxt;
         lv_r <= lv_nxt;
         fv_r <= fv_nxt;
         grn_r <= grn_nxt;
         redrow_r <= redrow_nxt;
         pclk_r <= pclk_nxt;
         rst_addr_r <= rst_addr_nxt;
         rst_stb_r <= rst_stb_nxt;
         acol_r <= acol_nxt;
         arow_r <= arow_nxt;
      end
   end

   // Port drivers, all from flip-flops
   assign PIX_DATA = pix_r;
   assign LINE_VALID = lv_r;
   assign FRAME_VALID = fv_r;
   assign PIX_GREEN = grn_r;
   assign PIX_RED_ROW = redrow_r;
   assign pixel_rate_clock_out = pclk_r;
   assign ROW_RESET_ADDR = rst_addr_r;
   assign ROW_RESET_STB = rst_stb_r;
   assign ARRAY_COL = acol_r;
   assign ARRAY_ROW = arow_r;
   assign ADC_EDGE = edge_r;
endmodule : sensor_readout
`default_nettype wire
